/* File: hdl/achi_top.sv */
// Purpose: digital control and output side of a 16-bit sampling converter
// Assumes: all control pins asynchronous to sys_clk_i; converter core outside
// Notes:   pin tristate is resolved outside from the enable outputs
//
// Overview of operation
// RULE1 - byte select low shows upper eight result bits, high shows lower eight
// RULE2 - parallel pin n carries bit n (select high) or bit n+8 (select low)
// RULE3 - parallel pins undriven while chip select high or read/convert low
// RULE4 - read/convert falling with chip select low and busy high starts a conversion
// RULE5 - read/convert rising with chip select low enables parallel drivers
// RULE6 - chip select ORed with read/convert; its falling edge also starts conversion
// RULE7 - with internal clock, the start edge begins shifting out previous result
// RULE8 - busy low from conversion start until new result is in outputs
// RULE9 - bit clock driven by device when source select low, host drives otherwise
// RULE10 - serial output changes in step with the bit clock
// RULE11 - power down switches off analog parts except reference, digital stays alive
// RULE12 - reference disable switches off the internal reference
// RULE13 - format select picks straight binary or two's complement for both outputs
// RULE14 - start edges while busy is low are ignored
`timescale 1ns/1ps
module achi_top #(
    parameter int RES_W    = achi_pkg::RES_W,
    parameter int HALF_CYC = achi_pkg::BIT_CLK_HALF_CYC
) (
    input  wire logic             sys_clk_i,                // 20 MHz clock
    input  wire logic             rst_n_i,                  // sync reset, active low
    input  wire logic             chip_select_n_i,          // chip select pin, low active
    input  wire logic             read_convert_i,           // read/convert pin
    input  wire logic             byte_select_i,            // byte select pin
    input  wire logic             clock_source_select_i,    // low: device drives bit clock
    input  wire logic             serial_bit_clock_i,       // bit clock pin, input side
    input  wire logic             analog_power_down_i,      // high: analog off
    input  wire logic             reference_disable_i,      // high: reference off
    input  wire logic             output_format_select_i,   // high: straight binary
    input  wire logic             core_valid_i,             // core result ready
    input  wire logic [RES_W-1:0] core_data_i,              // core result, straight binary
    output logic                  core_ready_o,             // buffer has room
    output logic                  conv_start_o,             // pulse: core starts sampling
    output logic                  analog_enable_o,          // analog sections on
    output logic                  reference_enable_o,       // internal reference on
    output logic                  busy_o,                   // high when idle
    output logic [7:0]            parallel_data_o,          // parallel pins, drive value
    output logic                  parallel_data_oe_o,       // parallel pins driven
    output logic                  serial_bit_clock_o,       // bit clock pin, drive value
    output logic                  serial_bit_clock_oe_o,    // bit clock pin driven
    output logic                  serial_result_out_o       // serial result pin
);
    localparam int DW = $clog2(HALF_CYC + 1);
    localparam int BW = $clog2(RES_W + 1);

    typedef struct packed {
        logic [achi_pkg::N_SYNC-1:0] s1;
        logic [achi_pkg::N_SYNC-1:0] s2;
        logic                        conv_n_q;
        logic                        bclk_in_q;
        achi_pkg::achi_conv_e        conv;
        achi_pkg::achi_ser_e         ser;
        logic [RES_W-1:0]            result;
        logic [RES_W-1:0]            shreg;
        logic [BW-1:0]               bits_left;
        logic [DW-1:0]               div;
        logic                        bclk;
        logic                        bclk_oe;
        logic                        sdo;
        logic                        busy;
        logic                        start;
        logic [7:0]                  pdata;
        logic                        poe;
        logic                        an_en;
        logic                        ref_en;
    } achi_top_s;

    achi_top_s        st;
    achi_top_s        next_st;
    logic             buf_valid;
    logic [RES_W-1:0] buf_data;
    logic             buf_take;

    // straight binary from the core; two's complement flips only the msb
    function automatic logic [RES_W-1:0] fmt_word(input logic [RES_W-1:0] x, input logic straight);
        fmt_word = straight ? x : {~x[RES_W-1], x[RES_W-2:0]};
    endfunction : fmt_word

    ////////////////////////////////////////////////////////////////////////
    // the buffer lets a result wait while an internally clocked serial readout is still running
    achi_buf2 #(
        .W     (RES_W),
        .DEPTH (achi_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_i       (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (core_valid_i),
        .in_data_i   (core_data_i),
        .in_ready_o  (core_ready_o),
        .out_valid_o (buf_valid),
        .out_data_o  (buf_data),
        .out_ready_i (buf_take)
    );

    assign buf_take = (st.conv == achi_pkg::ACHI_CONV) && (st.ser == achi_pkg::ACHI_SH_OFF);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic             conv_n;
        logic             start_evt;
        logic             internal;
        logic             straight;
        logic             bclk_fall;
        logic [RES_W-1:0] shown;
        conv_n    = 1'b1;
        start_evt = 1'b0;
        internal  = 1'b0;
        straight  = 1'b0;
        bclk_fall = 1'b0;
        shown     = '0;
        next_st   = st;
        if (!rst_n_i) begin
            next_st           = '0;
            next_st.s1        = achi_pkg::RST_SYNC;
            next_st.s2        = achi_pkg::RST_SYNC;
            next_st.conv_n_q  = 1'b1;
            next_st.conv      = achi_pkg::ACHI_IDLE;
            next_st.ser       = achi_pkg::ACHI_SH_OFF;
            next_st.busy      = achi_pkg::RST_BUSY;
            next_st.sdo       = achi_pkg::RST_SDO;
        end else begin
            next_st.s1 = {output_format_select_i, reference_disable_i, analog_power_down_i,
                          serial_bit_clock_i, clock_source_select_i, byte_select_i,
                          read_convert_i, chip_select_n_i};
            next_st.s2 = st.s1;
            conv_n     = st.s2[achi_pkg::SY_CS_N] | st.s2[achi_pkg::SY_RC]; // RULE6
            internal   = !st.s2[achi_pkg::SY_CLKSRC];
            straight   = st.s2[achi_pkg::SY_FMT];
            next_st.conv_n_q  = conv_n;
            next_st.bclk_in_q = st.s2[achi_pkg::SY_BCLK];
            bclk_fall  = st.bclk_in_q && !st.s2[achi_pkg::SY_BCLK];
            // edges while busy low fall through and change nothing
            start_evt  = st.conv_n_q && !conv_n && st.busy
                         && (st.conv == achi_pkg::ACHI_IDLE); // RULE4 RULE14
            next_st.start = start_evt;

            next_st.an_en  = !st.s2[achi_pkg::SY_PD];   // RULE11
            next_st.ref_en = !st.s2[achi_pkg::SY_REFERENCE_DISABLE]; // RULE12

            case (st.conv)
                achi_pkg::ACHI_IDLE: begin
                    if (start_evt) begin
                        next_st.busy = 1'b0; // RULE8
                        next_st.conv = achi_pkg::ACHI_CONV;
                    end
                end
                achi_pkg::ACHI_CONV: begin
                    if (buf_valid && buf_take) begin
                        next_st.result = buf_data;
                        next_st.busy   = 1'b1; // RULE8
                        next_st.conv   = achi_pkg::ACHI_IDLE;
                        if (!internal) begin
                            // host clock: new word is ready at once, msb first
                            next_st.shreg     = fmt_word(buf_data, straight); // RULE13
                            next_st.sdo       = next_st.shreg[RES_W-1];
                            next_st.bits_left = BW'(RES_W);
                        end
                    end
                end
                default: begin
                    next_st.conv = achi_pkg::ACHI_IDLE;
                end
            endcase

            next_st.bclk_oe = internal; // RULE9
            case (st.ser)
                achi_pkg::ACHI_SH_OFF: begin
                    next_st.bclk = 1'b0;
                    next_st.div  = '0;
                    if (start_evt && internal) begin
                        next_st.shreg     = fmt_word(st.result, straight); // RULE7 RULE13
                        next_st.sdo       = next_st.shreg[RES_W-1];
                        next_st.bits_left = BW'(RES_W);
                        next_st.ser       = achi_pkg::ACHI_SH_RUN;
                    end else if (!internal && bclk_fall && (st.bits_left != '0)) begin
                        next_st.shreg     = {st.shreg[RES_W-2:0], 1'b0}; // RULE10
                        next_st.sdo       = st.shreg[RES_W-2];
                        next_st.bits_left = st.bits_left - BW'(1);
                    end
                end
                achi_pkg::ACHI_SH_RUN: begin
                    if (st.div == DW'(HALF_CYC - 1)) begin
                        next_st.div  = '0;
                        next_st.bclk = !st.bclk;
                        if (st.bclk) begin
                            // host samples on the rise, data moves on the fall
                            next_st.shreg     = {st.shreg[RES_W-2:0], 1'b0}; // RULE10
                            next_st.sdo       = st.shreg[RES_W-2];
                            next_st.bits_left = st.bits_left - BW'(1);
                            if (st.bits_left == BW'(1)) begin
                                next_st.ser = achi_pkg::ACHI_SH_OFF;
                            end
                        end
                    end else begin
                        next_st.div = st.div + DW'(1);
                    end
                end
                default: begin
                    next_st.ser = achi_pkg::ACHI_SH_OFF;
                end
            endcase

            // next result, so the pins hold the new word when busy rises
            shown = fmt_word(next_st.result, straight); // RULE8 RULE13
            next_st.pdata = st.s2[achi_pkg::SY_BYTE] ? shown[7:0] : shown[15:8]; // RULE1 RULE2
            // level form covers the rising read/convert edge with select low
            next_st.poe = !st.s2[achi_pkg::SY_CS_N] && st.s2[achi_pkg::SY_RC]; // RULE3 RULE5
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    assign conv_start_o          = st.start;
    assign analog_enable_o       = st.an_en;
    assign reference_enable_o    = st.ref_en;
    assign busy_o                = st.busy;
    assign parallel_data_o       = st.pdata;
    assign parallel_data_oe_o    = st.poe;
    assign serial_bit_clock_o    = st.bclk;
    assign serial_bit_clock_oe_o = st.bclk_oe;
    assign serial_result_out_o   = st.sdo;

endmodule : achi_top

/* File: common/achi_pkg.sv */
// Purpose: shared constants and state types of the converter host interface
// Assumes: 20 MHz system clock, 16-bit result from the converter core
// Notes:   no register map; every control bit is a plain pin
package achi_pkg;

    localparam int RES_W   = 16;
    localparam int BYTE_W  = 8;
    localparam int N_SYNC  = 8;
    localparam int BUF_DEPTH = 2;

    // positions of the pin inputs inside the synchroniser vector
    localparam int SY_CS_N   = 0;
    localparam int SY_RC     = 1;
    localparam int SY_BYTE   = 2;
    localparam int SY_CLKSRC = 3;
    localparam int SY_BCLK   = 4;
    localparam int SY_PD     = 5;
    localparam int SY_REFERENCE_DISABLE   = 6;
    localparam int SY_FMT    = 7;

    // timing
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int BIT_CLK_HALF_NS   = 200;
    localparam int BIT_CLK_HALF_CYC  = (BIT_CLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // reset values
    localparam logic       RST_BUSY   = 1'b1;
    localparam logic       RST_SDO    = 1'b0;
    localparam logic [7:0] RST_SYNC   = 8'h03;

    typedef enum logic [1:0] {
        ACHI_IDLE = 2'b01,
        ACHI_CONV = 2'b10
    } achi_conv_e;

    typedef enum logic [1:0] {
        ACHI_SH_OFF = 2'b01,
        ACHI_SH_RUN = 2'b10
    } achi_ser_e;

endpackage : achi_pkg

/* File: hdl/achi_buf2.sv */
// Purpose: small result buffer between converter core and output registers
// Assumes: single clock, synchronous active-low reset
// Notes:   ready and valid come straight from stored flags
`timescale 1ns/1ps
module achi_buf2 #(
    parameter int W     = 16,
    parameter int DEPTH = 2
) (
    input  wire logic         clk_i,        // system clock
    input  wire logic         rst_n_i,      // sync reset, active low
    input  wire logic         in_valid_i,   // word offered
    input  wire logic [W-1:0] in_data_i,    // word
    output logic              in_ready_o,   // room for a word
    output logic              out_valid_o,  // word available
    output logic [W-1:0]      out_data_o,   // oldest word
    input  wire logic         out_ready_i   // drain takes the word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    ready;
        logic                    valid;
    } achi_buf_s;

    achi_buf_s st;
    achi_buf_s next_st;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic push;
        logic pop;
        push    = 1'b0;
        pop     = 1'b0;
        next_st = st;
        if (!rst_n_i) begin
            next_st       = '0;
            next_st.ready = 1'b1;
        end else begin
            push = in_valid_i && st.ready;
            pop  = out_ready_i && st.valid;
            if (push) begin
                next_st.mem[st.wp] = in_data_i;
                next_st.wp         = ptr_inc(st.wp);
            end
            if (pop) begin
                next_st.rp = ptr_inc(st.rp);
            end
            if (push && !pop) begin
                next_st.cnt = st.cnt + CW'(1);
            end else if (pop && !push) begin
                next_st.cnt = st.cnt - CW'(1);
            end
            next_st.ready = (next_st.cnt != CW'(DEPTH));
            next_st.valid = (next_st.cnt != '0);
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign in_ready_o  = st.ready;
    assign out_valid_o = st.valid;
    assign out_data_o  = st.mem[st.rp];

endmodule : achi_buf2

/* File: dv/achi_props.sv */
// Purpose: pin-level timing checks of the converter host interface
// Assumes: pins held at least 4 cycles around each checked level
// Notes:   bound into every achi_top instance
`timescale 1ns/1ps
module achi_props (
    input wire logic sys_clk_i,             // clock
    input wire logic rst_n_i,               // sync reset
    input wire logic chip_select_n_i,       // pin
    input wire logic read_convert_i,        // pin
    input wire logic clock_source_select_i, // pin
    input wire logic analog_power_down_i,   // pin
    input wire logic reference_disable_i,   // pin
    input wire logic core_valid_i,          // core offer
    input wire logic core_ready_o,          // buffer room
    input wire logic conv_start_o,          // start pulse
    input wire logic analog_enable_o,       // analog on
    input wire logic reference_enable_o,    // reference on
    input wire logic busy_o,                // idle flag
    input wire logic parallel_data_oe_o,    // pins driven
    input wire logic serial_bit_clock_o,    // bit clock
    input wire logic serial_bit_clock_oe_o, // bit clock driven
    input wire logic serial_result_out_o    // serial bit
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////
    property p_oe_off; (chip_select_n_i || !read_convert_i)[*4] |-> !parallel_data_oe_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("parallel pins driven while deselected");
    property p_oe_on; (!chip_select_n_i && read_convert_i)[*4] |-> parallel_data_oe_o; endproperty
    a_oe_on: assert property (p_oe_on) else $error("parallel pins not driven for read");
    property p_start_idle; conv_start_o |-> !busy_o && $past(busy_o); endproperty
    a_start_idle: assert property (p_start_idle) else $error("start without idle busy");
    property p_ignore; !busy_o |=> !conv_start_o; endproperty
    a_ignore: assert property (p_ignore) else $error("start while converting");
    property p_busy_fall; $fell(busy_o) |-> conv_start_o; endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell without start");
    property p_busy_done; !busy_o && core_valid_i && core_ready_o |-> ##[1:300] busy_o; endproperty
    a_busy_done: assert property (p_busy_done) else $error("busy stuck after result");
    property p_bclk_int; (!clock_source_select_i)[*4] |-> serial_bit_clock_oe_o; endproperty
    a_bclk_int: assert property (p_bclk_int) else $error("bit clock not driven in internal mode");
    property p_sdo_rise; serial_bit_clock_oe_o && $rose(serial_bit_clock_o) |-> $stable(serial_result_out_o); endproperty
    a_sdo_rise: assert property (p_sdo_rise) else $error("serial bit moved on sampling edge");
    property p_pd_off; analog_power_down_i[*6] |-> !analog_enable_o; endproperty
    a_pd_off: assert property (p_pd_off) else $error("analog on in power down");
    property p_pd_on; (!analog_power_down_i)[*6] |-> analog_enable_o; endproperty
    a_pd_on: assert property (p_pd_on) else $error("analog off without power down");
    property p_ref_off; reference_disable_i[*6] |-> !reference_enable_o; endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference on while disabled");
    c_start: cover property (conv_start_o);
    c_bclk: cover property (serial_bit_clock_oe_o && $rose(serial_bit_clock_o));
    c_full: cover property (!core_ready_o);
endmodule : achi_props
bind achi_top achi_props u_props (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(chip_select_n_i),
    .read_convert_i(read_convert_i), .clock_source_select_i(clock_source_select_i),
    .analog_power_down_i(analog_power_down_i), .reference_disable_i(reference_disable_i),
    .core_valid_i(core_valid_i), .core_ready_o(core_ready_o), .conv_start_o(conv_start_o),
    .analog_enable_o(analog_enable_o), .reference_enable_o(reference_enable_o), .busy_o(busy_o),
    .parallel_data_oe_o(parallel_data_oe_o), .serial_bit_clock_o(serial_bit_clock_o),
    .serial_bit_clock_oe_o(serial_bit_clock_oe_o), .serial_result_out_o(serial_result_out_o)
);

/* File: dv/achi_host_model.sv */
// Purpose: host side of the serial link, clock source and receiver
// Assumes: 400 ns bit clock period when the host supplies the clock
// Notes:   clock stands low between frames
`timescale 1ns/1ps
module achi_host_model (
    input  wire logic   bclk_wire_i, // resolved bit clock pin
    input  wire logic   sdo_i,       // serial result pin
    output logic        host_bclk_o, // host bit clock drive
    output logic [15:0] word_o       // last 16 bits received
);
    initial host_bclk_o = 1'b0;
    initial word_o = 16'h0000;
    // sample on rise, device moves the bit on fall
    always @(posedge bclk_wire_i) word_o <= {word_o[14:0], sdo_i};
    task automatic run_frame(input int nbits);
        #13;
        for (int i = 0; i < nbits; i++) begin
            #200 host_bclk_o = 1'b1;
            #200 host_bclk_o = 1'b0;
        end
    endtask : run_frame
endmodule : achi_host_model

/* File: dv/tb.sv */
// Purpose: self-checking bench of the converter host interface
// Assumes: core modelled by push, host serial side by achi_host_model
// Notes:   pins held several cycles so the synchronisers settle
`timescale 1ns/1ps
module tb;
    logic        sys_clk_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic        cs_n      = 1'b1;
    logic        rc        = 1'b1;
    logic        bsel      = 1'b0;
    logic        csrc      = 1'b1;
    logic        pd        = 1'b0;
    logic        reference_disable      = 1'b0;
    logic        fmt       = 1'b1;
    logic        cvalid    = 1'b0;
    logic [15:0] cdata     = 16'h0000;
    logic        cready, start, aen, ren, busy, poe, bclk_d, bclk_oe, sdo, host_bclk;
    logic [7:0]  pdata;
    logic [15:0] hword;
    logic [15:0] w_tab [4] = '{16'h3C5A, 16'hA5C3, 16'h8001, 16'h7FFE};
    wire         bclk_wire = bclk_oe ? bclk_d : host_bclk;
    int          error_cnt = 0;
    int          compares  = 0;
    int          cyc       = 0;
    int          nstart    = 0;
    int          n0;
    always #25 sys_clk_i = ~sys_clk_i;
    achi_top #(.HALF_CYC(4)) DUT (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n), .read_convert_i(rc),
        .byte_select_i(bsel), .clock_source_select_i(csrc), .serial_bit_clock_i(bclk_wire),
        .analog_power_down_i(pd), .reference_disable_i(reference_disable), .output_format_select_i(fmt),
        .core_valid_i(cvalid), .core_data_i(cdata), .core_ready_o(cready), .conv_start_o(start),
        .analog_enable_o(aen), .reference_enable_o(ren), .busy_o(busy), .parallel_data_o(pdata),
        .parallel_data_oe_o(poe), .serial_bit_clock_o(bclk_d), .serial_bit_clock_oe_o(bclk_oe),
        .serial_result_out_o(sdo)
    );
    achi_host_model u_host (.bclk_wire_i(bclk_wire), .sdo_i(sdo), .host_bclk_o(host_bclk), .word_o(hword));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] fmtd(input logic [15:0] w, input logic f);
        return f ? w : {~w[15], w[14:0]};
    endfunction : fmtd
    task automatic conclude();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 400 && busy !== lvl; i++) @(posedge sys_clk_i);
        check("busy", 16'(busy), 16'(lvl));
    endtask : wait_busy
    // host start sequence: idle high for 3 cycles, then one falling edge
    task automatic conv(input logic via_cs);
        cs_n <= 1'b1;
        rc   <= 1'b1;
        tick(3);
        if (via_cs) begin
            rc <= 1'b0;
            tick(3);
            cs_n <= 1'b0;
        end else begin
            cs_n <= 1'b0;
            tick(3);
            rc <= 1'b0;
        end
        wait_busy(1'b0);
        rc <= 1'b1;
    endtask : conv
    task automatic push(input logic [15:0] w);
        @(posedge sys_clk_i);
        cvalid <= 1'b1;
        cdata  <= w;
        for (int i = 0; i < 400; i++) begin
            @(posedge sys_clk_i);
            if (cready === 1'b1) break;
        end
        cvalid <= 1'b0;
    endtask : push
    task automatic read_bytes(input logic [15:0] w);
        for (int b = 0; b < 2; b++) begin
            bsel <= b[0];
            tick(5);
            check("pdata", 16'(pdata), 16'(b ? w[7:0] : w[15:8]));
        end
        check("poe", 16'(poe), 16'h0001);
    endtask : read_bytes
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (start === 1'b1) nstart <= nstart + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        rst_n_i <= 1'b1;
        tick(1);
        check("busy", 16'(busy), 16'h0001);
        check("poe", 16'(poe), 16'h0000);
        for (int f = 0; f < 2; f++) begin
            fmt <= f[0];
            conv(f[0]);
            push(w_tab[f]);
            wait_busy(1'b1);
            check("pdata_new", 16'(pdata), f ? 16'(w_tab[f][7:0]) : fmtd(w_tab[f], 1'b0) >> 8);
            read_bytes(fmtd(w_tab[f], f[0]));
            cs_n <= 1'b1;
            tick(5);
            check("poe", 16'(poe), 16'h0000);
        end
        $display("test format done");
        n0 = nstart;
        conv(1'b0);
        tick(3);
        rc <= 1'b0;
        tick(6);
        check("starts", 16'(nstart - n0), 16'h0001);
        rc <= 1'b1;
        push(w_tab[0]);
        wait_busy(1'b1);
        $display("test ignore done");
        push(w_tab[2]);
        push(w_tab[3]);
        tick(1);
        cvalid <= 1'b1;
        cdata  <= 16'hFFFF;
        tick(4);
        check("ready", 16'(cready), 16'h0000);
        cvalid <= 1'b0;
        for (int k = 2; k < 4; k++) begin
            conv(1'b0);
            wait_busy(1'b1);
            read_bytes(w_tab[k]);
        end
        check("ready", 16'(cready), 16'h0001);
        $display("test buffer done");
        csrc <= 1'b0;
        tick(5);
        check("bclk_oe", 16'(bclk_oe), 16'h0001);
        conv(1'b0);
        push(16'h1234);
        wait_busy(1'b1);
        check("serial_int", hword, w_tab[3]);
        $display("test serial internal done");
        csrc <= 1'b1;
        fmt  <= 1'b0;
        conv(1'b1);
        check("bclk_oe", 16'(bclk_oe), 16'h0000);
        push(16'hC3A5);
        wait_busy(1'b1);
        u_host.run_frame(16);
        tick(4);
        check("serial_ext", hword, fmtd(16'hC3A5, 1'b0));
        $display("test serial external done");
        pd   <= 1'b1;
        reference_disable <= 1'b1;
        conv(1'b0);
        push(16'h0F0F);
        wait_busy(1'b1);
        check("aen", 16'(aen), 16'h0000);
        check("ren", 16'(ren), 16'h0000);
        pd   <= 1'b0;
        reference_disable <= 1'b0;
        tick(6);
        check("aen", 16'(aen), 16'h0001);
        check("ren", 16'(ren), 16'h0001);
        $display("test power done");
        conclude();
    end
endmodule : tb
